// file: src/pmdc_ctrl.sv
`timescale 1ns/100ps
`include "pmdc_params.svh"
module pmdc_ctrl #(
	parameter int WAKE_CYC = `PMDC_WAKE_CYC,
	parameter int REF_INT_CYC = `PMDC_REF_INT_CYC,
	parameter int PHASE_CYC = `PMDC_PHASE_CYC
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire pmdc_pkg::pmdc_req_t req,
	input wire logic refresh_lapsed,
	output logic req_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic ready_for_access,
	output pmdc_pkg::pmdc_pins_t pins,
	input wire logic [15:0] dq_in
);
	if (WAKE_CYC < 1 || PHASE_CYC < 1 || PHASE_CYC > 255) begin
		$error("pmdc_ctrl: bad timing parameter");
	end
	//------------------------------------------------
	// State
	//------------------------------------------------
	typedef struct packed {
		pmdc_pkg::pmdc_state_t state;
		pmdc_pkg::pmdc_req_t cur;
		logic [31:0] wait_cnt;
		logic [7:0] ph;
		logic [3:0] wake_left;
		logic [9:0] owed;
		logic awake;
		logic lapse;
		logic ready;
		logic rvalid;
		logic [15:0] rdata;
		pmdc_pkg::pmdc_pins_t pins;
	} pmdc_ctrl_st_t;
	pmdc_ctrl_st_t st_reg, st_next;
	logic ref_tick;
	pmdc_tick #(
		.INTERVAL(REF_INT_CYC)
	) u_tick (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.restart(!st_reg.awake),
		.tick(ref_tick)
	);
	function automatic logic phase_done(input logic [7:0] ph);
		return ph == 8'(PHASE_CYC - 1);
	endfunction
	function automatic pmdc_pkg::pmdc_pins_t pins_idle();
		pmdc_pkg::pmdc_pins_t p;
		p = '0;
		p.row_strobe_n = 1'b1;
		p.low_byte_col_strobe_n = 1'b1;
		p.high_byte_col_strobe_n = 1'b1;
		p.write_strobe_n = 1'b1;
		p.output_gate_n = 1'b1;
		return p;
	endfunction
	always_comb begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		st_next.ph = st_reg.ph + 8'h1;
		if (ref_tick && st_reg.owed != 10'h3ff) begin
			st_next.owed = st_reg.owed + 10'h1;
		end
		// Lapse kept until idle can start the wake-up
		if (refresh_lapsed && st_reg.awake) begin
			st_next.lapse = 1'b1;
		end
		case (st_reg.state)
		pmdc_pkg::ST_WAKE: begin
			st_next.pins = pins_idle();
			st_next.ph = '0;
			if (st_reg.wait_cnt != 32'(WAKE_CYC)) begin
				st_next.wait_cnt = st_reg.wait_cnt + 32'h1;
			end else begin
				st_next.state = pmdc_pkg::ST_CBR_COL;
			end
		end
		pmdc_pkg::ST_IDLE: begin
			st_next.pins = pins_idle();
			st_next.ph = '0;
			if (req_valid && st_reg.ready) begin
				// Offered handshake always honoured
				st_next.cur = req;
				st_next.ready = 1'b0;
				st_next.pins.addr = req.row;
				st_next.pins.row_strobe_n = 1'b0;
				st_next.state = pmdc_pkg::ST_ROW;
			end else if (st_reg.lapse || refresh_lapsed) begin
				st_next.lapse = 1'b0;
				st_next.awake = 1'b0;
				st_next.ready = 1'b0;
				st_next.wake_left = 4'(`PMDC_WAKE_REFRESHES);
				st_next.state = pmdc_pkg::ST_CBR_COL;
			end else if (st_reg.owed != '0) begin
				st_next.ready = 1'b0;
				st_next.state = pmdc_pkg::ST_CBR_COL;
			end else begin
				st_next.ready = st_reg.awake;
			end
		end
		pmdc_pkg::ST_ROW: begin
			st_next.pins.addr = st_reg.cur.col;
			if (phase_done(st_reg.ph)) begin
				st_next.ph = '0;
				st_next.state = pmdc_pkg::ST_COL;
				if (st_reg.cur.op == pmdc_pkg::OP_EARLY_WRITE) begin
					st_next.pins.write_strobe_n = 1'b0;
					st_next.pins.dq_out = st_reg.cur.wdata;
					st_next.pins.dq_oe = 1'b1;
				end else if (st_reg.cur.op != pmdc_pkg::OP_LATE_WRITE) begin
					st_next.pins.output_gate_n = 1'b0;
				end
				// Per byte strobes
				st_next.pins.low_byte_col_strobe_n = !st_reg.cur.byte_en[0];
				st_next.pins.high_byte_col_strobe_n = !st_reg.cur.byte_en[1];
			end
		end
		pmdc_pkg::ST_COL: begin
			if (phase_done(st_reg.ph)) begin
				st_next.ph = '0;
				if (st_reg.cur.op == pmdc_pkg::OP_READ ||
					st_reg.cur.op == pmdc_pkg::OP_RMW) begin
					st_next.rdata = dq_in;
				end
				if (st_reg.cur.op == pmdc_pkg::OP_READ) begin
					st_next.rvalid = 1'b1;
					st_next.state = pmdc_pkg::ST_RPRE;
				end else if (st_reg.cur.op == pmdc_pkg::OP_EARLY_WRITE) begin
					st_next.state = pmdc_pkg::ST_RPRE;
				end else begin
					// Gate driven, never tied low
					st_next.pins.output_gate_n = 1'b1;
					st_next.state = pmdc_pkg::ST_GATE;
				end
			end
		end
		pmdc_pkg::ST_GATE: begin
			if (phase_done(st_reg.ph)) begin
				st_next.ph = '0;
				// Write only after a full gate phase
				st_next.pins.write_strobe_n = 1'b0;
				st_next.pins.dq_out = st_reg.cur.wdata;
				st_next.pins.dq_oe = 1'b1;
				st_next.rvalid = st_reg.cur.op == pmdc_pkg::OP_RMW;
				st_next.state = pmdc_pkg::ST_LATE;
			end
		end
		pmdc_pkg::ST_LATE: begin
			if (phase_done(st_reg.ph)) begin
				st_next.ph = '0;
				st_next.state = pmdc_pkg::ST_RPRE;
			end
		end
		pmdc_pkg::ST_RPRE: begin
			// Read hold past both rises, then full precharge
			st_next.pins = pins_idle();
			st_next.pins.write_strobe_n = st_reg.pins.write_strobe_n;
			if (phase_done(st_reg.ph)) begin
				st_next.ph = '0;
				st_next.pins = pins_idle();
				st_next.state = pmdc_pkg::ST_IDLE;
			end
		end
		pmdc_pkg::ST_CBR_COL: begin
			// Refresh starts from full precharge
			st_next.pins = pins_idle();
			st_next.pins.low_byte_col_strobe_n = 1'b0;
			st_next.pins.high_byte_col_strobe_n = 1'b0;
			if (phase_done(st_reg.ph)) begin
				st_next.ph = '0;
				st_next.pins.row_strobe_n = 1'b0;
				st_next.state = pmdc_pkg::ST_CBR_ROW;
			end
		end
		pmdc_pkg::ST_CBR_ROW: begin
			if (phase_done(st_reg.ph)) begin
				st_next.ph = '0;
				st_next.pins = pins_idle();
				st_next.state = pmdc_pkg::ST_CBR_END;
			end
		end
		pmdc_pkg::ST_CBR_END: begin
			if (phase_done(st_reg.ph)) begin
				st_next.ph = '0;
				// Device row counter advances itself
				if (st_reg.owed != '0) begin
					// Tick in this cycle cancels the service
					st_next.owed = ref_tick ? st_reg.owed :
						st_reg.owed - 10'h1;
				end
				if (st_reg.wake_left > 4'h1) begin
					st_next.wake_left = st_reg.wake_left - 4'h1;
					st_next.state = pmdc_pkg::ST_CBR_COL;
				end else begin
					st_next.wake_left = '0;
					st_next.awake = 1'b1;
					st_next.state = pmdc_pkg::ST_IDLE;
				end
			end
		end
		default: begin
			st_next.state = pmdc_pkg::ST_IDLE;
		end
		endcase
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
			st_reg.state <= pmdc_pkg::ST_WAKE;
			st_reg.wake_left <= 4'(`PMDC_WAKE_REFRESHES);
			st_reg.pins <= pins_idle();
		end else begin
			st_reg <= st_next;
		end
	end
	assign req_ready = st_reg.ready;
	assign rsp_valid = st_reg.rvalid;
	assign rsp_data = st_reg.rdata;
	assign ready_for_access = st_reg.awake;
	assign pins = st_reg.pins;
endmodule

// file: common/pmdc_params.svh
`ifndef PMDC_PARAMS_SVH
`define PMDC_PARAMS_SVH
// How it works
// - Wait 200 us, eight refreshes, then access
// - Repeat eight-refresh wake-up after refresh lapse
// - Raise both strobes to clear output
// - Read strobe held high past strobe rise
// - Odd write timing leaves output undefined
// - Gate tied low forbids late writes
// - Write command is write strobe falling
// - Gate high during late write data drive
// - Each byte strobe meets pulse width
// - Hidden refresh keeps column strobe low
// - All 512 rows refreshed every 8 ms
//------------------------------------------------
// Timing
//------------------------------------------------
`define PMDC_CLK_NS 25
`define PMDC_WAKE_US 200
`define PMDC_WAKE_CYC ((`PMDC_WAKE_US * 1000) / `PMDC_CLK_NS)
`define PMDC_WAKE_REFRESHES 8
`define PMDC_REF_PERIOD_MS 8
`define PMDC_REF_ROWS 512
`define PMDC_REF_INT_CYC \
	((`PMDC_REF_PERIOD_MS * 1000000) / `PMDC_CLK_NS / `PMDC_REF_ROWS)
`define PMDC_PHASE_CYC 2
`endif

// file: common/pmdc_pkg.sv
package pmdc_pkg;
	typedef enum logic [3:0] {
		ST_WAKE = 4'h0,
		ST_IDLE = 4'h1,
		ST_ROW = 4'h2,
		ST_COL = 4'h3,
		ST_LATE = 4'h4,
		ST_GATE = 4'h5,
		ST_RPRE = 4'h6,
		ST_CBR_COL = 4'h7,
		ST_CBR_ROW = 4'h8,
		ST_CBR_END = 4'h9
	} pmdc_state_t;
	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_EARLY_WRITE = 2'h1,
		OP_LATE_WRITE = 2'h2,
		OP_RMW = 2'h3
	} pmdc_op_t;
	typedef struct packed {
		pmdc_op_t op;
		logic [8:0] row;
		logic [8:0] col;
		logic [1:0] byte_en;
		logic [15:0] wdata;
	} pmdc_req_t;
	typedef struct packed {
		logic row_strobe_n;
		logic low_byte_col_strobe_n;
		logic high_byte_col_strobe_n;
		logic write_strobe_n;
		logic output_gate_n;
		logic [8:0] addr;
		logic [15:0] dq_out;
		logic dq_oe;
	} pmdc_pins_t;
endpackage

// file: src/pmdc_tick.sv
`timescale 1ns/100ps
`include "pmdc_params.svh"
module pmdc_tick #(
	parameter int INTERVAL = `PMDC_REF_INT_CYC
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic restart,
	output logic tick
);
	if (INTERVAL < 2) begin
		$error("pmdc_tick: interval too short");
	end
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} pmdc_tick_st_t;
	pmdc_tick_st_t st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (restart || st_reg.cnt == 32'(INTERVAL - 1)) begin
			st_next.cnt = '0;
			st_next.tick = !restart;
		end else begin
			st_next.cnt = st_reg.cnt + 32'h1;
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign tick = st_reg.tick;
endmodule

// file: tb/pmdc_ctrl_assertions.sv
`timescale 1ns/100ps
// ----
// Pin and handshake protocol checks
// ----
module pmdc_ctrl_assertions #(
	parameter int WAKE_CYC = 20,
	parameter int REF_INT_CYC = 50,
	parameter int PHASE_CYC = 2
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire pmdc_pkg::pmdc_req_t req,
	input wire logic refresh_lapsed,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic ready_for_access,
	input wire pmdc_pkg::pmdc_pins_t pins,
	input wire logic [15:0] dq_in
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	int gap_reg;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n || !ready_for_access || !pins.row_strobe_n)
			gap_reg <= 0;
		else
			gap_reg <= gap_reg + 1;
	end
	wake_gate_a:
		assert property (!ready_for_access |-> !req_ready)
		else $error("request accepted before wake-up");
	wake_pause_a:
		assert property ($rose(reset_n) |-> pins.row_strobe_n [*8])
		else $error("row strobe during power-up pause");
	read_hold_a:
		assert property (req_valid && req_ready && req.op ==
			pmdc_pkg::OP_READ |=> pins.write_strobe_n [*6])
		else $error("write strobe low in read");
	late_gate_a:
		assert property ($fell(pins.write_strobe_n) |-> pins.output_gate_n)
		else $error("write with output gate low");
	drive_gate_a:
		assert property (pins.dq_oe |-> pins.output_gate_n &&
			!pins.row_strobe_n)
		else $error("data driven against device");
	write_row_a:
		assert property ($fell(pins.write_strobe_n) |-> !pins.row_strobe_n)
		else $error("write command outside row cycle");
	low_width_a:
		assert property ($fell(pins.low_byte_col_strobe_n) |->
			!pins.low_byte_col_strobe_n [*2])
		else $error("low byte strobe too short");
	high_width_a:
		assert property ($fell(pins.high_byte_col_strobe_n) |->
			!pins.high_byte_col_strobe_n [*2])
		else $error("high byte strobe too short");
	refresh_gap_a:
		assert property (gap_reg < 2 * REF_INT_CYC)
		else $error("refresh interval exceeded");
	lapse_wake_a:
		assert property ($rose(refresh_lapsed) |-> ##2 !req_ready [*6])
		else $error("access allowed after refresh lapse");
endmodule
bind pmdc_ctrl pmdc_ctrl_assertions #(.WAKE_CYC(WAKE_CYC),
	.REF_INT_CYC(REF_INT_CYC), .PHASE_CYC(PHASE_CYC)) i_chk (
	.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid),
	.req(req), .refresh_lapsed(refresh_lapsed), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .rsp_data(rsp_data),
	.ready_for_access(ready_for_access), .pins(pins), .dq_in(dq_in));

// file: tb/pmdc_dram_model.sv
`timescale 1ns/100ps
// ----
// Word memory
// ----
module pmdc_dram_model (
	input wire pmdc_pkg::pmdc_pins_t pins,
	output logic [15:0] dq_in
);
	bit [15:0] mem [262144];
	logic [8:0] row = 9'h000;
	logic [8:0] col = 9'h000;
	logic [8:0] ref_row = 9'h000;
	logic [15:0] q = 16'h0000;
	logic strobe_order_refresh = 1'b0;
	wire lo = !pins.low_byte_col_strobe_n;
	wire hi = !pins.high_byte_col_strobe_n;
	wire rd = !strobe_order_refresh && !pins.output_gate_n && pins.write_strobe_n;
	// Store enabled bytes of the bus into the word
	task automatic put();
		if (lo) q[7:0] = dq_in[7:0];
		if (hi) q[15:8] = dq_in[15:8];
		mem[{row, col}] = q;
	endtask
	always @(negedge pins.row_strobe_n) begin
		strobe_order_refresh = lo || hi;
		if (strobe_order_refresh) ref_row = ref_row + 9'h001;
		else row = pins.addr;
	end
	always @(posedge pins.row_strobe_n) strobe_order_refresh = 1'b0;
	always @(negedge pins.low_byte_col_strobe_n or
		negedge pins.high_byte_col_strobe_n) begin
		if (!strobe_order_refresh && !pins.row_strobe_n) begin
			col = pins.addr;
			q = mem[{row, col}];
			#1 if (!pins.write_strobe_n) put();
		end
	end
	always @(negedge pins.write_strobe_n) begin
		#1 if (!strobe_order_refresh && (lo || hi)) put();
	end
	assign dq_in[7:0] = pins.dq_oe ? pins.dq_out[7:0] :
		rd && lo ? q[7:0] : ~q[7:0];
	assign dq_in[15:8] = pins.dq_oe ? pins.dq_out[15:8] :
		rd && hi ? q[15:8] : ~q[15:8];
endmodule

// file: tb/page_mode_dram_cycle_protocol_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) \
	begin \
		total_checks++; \
		if ((a) !== (b)) begin \
			bad_count++; \
			$display("Error at %0t: got %h expected %h", $time, a, b); \
		end \
	end
// ----
// Bench
// ----
module page_mode_dram_cycle_protocol_bench;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic req_valid = 1'b0;
	pmdc_pkg::pmdc_req_t req = '0;
	logic refresh_lapsed = 1'b0;
	logic req_ready;
	logic rsp_valid;
	logic [15:0] rsp_data;
	logic ready_for_access;
	pmdc_pkg::pmdc_pins_t pins;
	logic [15:0] dq_in;
	bit [15:0] shadow [262144];
	pmdc_pkg::pmdc_req_t r;
	int seed = 53;
	int bad_count = 0;
	int total_checks = 0;
	int n;
	logic [8:0] ref0;
	always #12.5 sys_clk = ~sys_clk;
	pmdc_ctrl #(.WAKE_CYC(20), .REF_INT_CYC(50), .PHASE_CYC(2)) i_dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid),
		.req(req), .refresh_lapsed(refresh_lapsed), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.ready_for_access(ready_for_access), .pins(pins), .dq_in(dq_in));
	pmdc_dram_model i_mem (.pins(pins), .dq_in(dq_in));
	task automatic end_sim();
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wait_for(input int sel);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while ((sel == 2 ? ready_for_access : sel == 1 ? rsp_valid :
			req_ready) !== 1'b1 && n < 400);
		if (n >= 400) begin
			bad_count++;
			end_sim();
		end
	endtask
	function automatic logic [15:0] byte_mask(input logic [1:0] be);
		return {{8{be[1]}}, {8{be[0]}}};
	endfunction
	task automatic access(input pmdc_pkg::pmdc_req_t a);
		logic [15:0] m;
		logic [15:0] e;
		m = byte_mask(a.byte_en);
		e = shadow[{a.row, a.col}];
		req <= a;
		req_valid <= 1'b1;
		wait_for(0);
		req_valid <= 1'b0;
		if (a.op != pmdc_pkg::OP_READ)
			shadow[{a.row, a.col}] = (e & ~m) | (a.wdata & m);
		if (a.op == pmdc_pkg::OP_READ || a.op == pmdc_pkg::OP_RMW) begin
			wait_for(1);
			`CHK(rsp_data & m, e & m)
		end else
			@(posedge sys_clk);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		wait_for(2);
		`CHK(n >= 68, 1'b1)
		`CHK(i_mem.ref_row, 9'h008)
		access('{pmdc_pkg::OP_EARLY_WRITE, 9'h1ff, 9'h000, 2'h1, 16'ha55a});
		access('{pmdc_pkg::OP_LATE_WRITE, 9'h1ff, 9'h000, 2'h2, 16'h3cc3});
		access('{pmdc_pkg::OP_READ, 9'h1ff, 9'h000, 2'h3, 16'h0000});
		access('{pmdc_pkg::OP_RMW, 9'h1ff, 9'h000, 2'h3, 16'h0ff0});
		access('{pmdc_pkg::OP_READ, 9'h1ff, 9'h000, 2'h2, 16'h0000});
		ref0 = i_mem.ref_row;
		refresh_lapsed <= 1'b1;
		repeat (3) @(posedge sys_clk);
		refresh_lapsed <= 1'b0;
		access('{pmdc_pkg::OP_READ, 9'h1ff, 9'h000, 2'h3, 16'h0000});
		`CHK((i_mem.ref_row - ref0) >= 9'h008, 1'b1)
		repeat (60) begin
			r.op = pmdc_pkg::pmdc_op_t'(2'($random(seed)));
			r.row = 9'($random(seed)) & 9'h003;
			r.col = 9'($random(seed)) & 9'h007;
			r.byte_en = 2'($random(seed));
			if (r.byte_en == 2'h0) r.byte_en = 2'h3;
			r.wdata = 16'($random(seed));
			access(r);
		end
		end_sim();
	end
endmodule
